/* verilog/focc_defs.vh */
`ifndef FOCC_DEFS_VH
`define FOCC_DEFS_VH
// Register offsets
`define FOCC_CH6_CFG_ADDR    8'h0f
`define FOCC_CH6_INTDIV_ADDR 8'h10
`define FOCC_CH6_FRACLO_ADDR 8'h11
`define FOCC_CH7_CFG_ADDR    8'h12
`define FOCC_REG_RESET       16'h0000
`define FOCC_READ_UNMAPPED   16'h0000
// Channel configuration fields
`define FOCC_PRESCALE_HI     12
`define FOCC_PRESCALE_LO     10
`define FOCC_FRAC_EN_BIT     9
`define FOCC_EDGE_BIT        8
`define FOCC_NEG_EN_BIT      7
`define FOCC_POS_EN_BIT      6
`define FOCC_DRV_HI          4
`define FOCC_DRV_LO          3
`define FOCC_OUT_EN_HI       2
`define FOCC_OUT_EN_LO       1
`define FOCC_SUPPLY_BIT      0
// Integer divider and fraction fields
`define FOCC_INTDIV_HI       11
`define FOCC_INTDIV_LO       4
`define FOCC_FRACHI_HI       3
`define FOCC_FRACHI_LO       0
// Pre-divider codes and factors
`define FOCC_PRE_DIV2        3'h2
`define FOCC_PRE_DIV3        3'h3
`define FOCC_PRE_DIV1        3'h1
`define FOCC_PRE_CODE_DIV2   3'h0
`define FOCC_PRE_CODE_DIV3   3'h1
`define FOCC_PRE_CODE_DIV1   3'h7
`define FOCC_PRE_BYPASS      3'h1
`define FOCC_PRE_RESERVED    3'h0
// Driver type codes
`define FOCC_DRV_CMOS        2'h2
`define FOCC_DRV_HCSL        2'h3
// Channel enable codes
`define FOCC_EN_OFF          2'h0
`define FOCC_EN_CLOCK        2'h1
`define FOCC_EN_LOW          2'h2
`define FOCC_EN_HIGH         2'h3
`endif

/* verilog/focc_regs.v */
`include "focc_defs.vh"

// Summary of operation
// RULE1 - Channel 6 integer divide equals field plus one
// RULE2 - Fraction: high four bits, then sixteen low
// RULE3 - Pre-divider codes: 000 div2, 001 div3, 111 div1
// RULE4 - Pre-divider bypassed when fraction enable is zero
// RULE5 - Bit 9 enables the fractional divider
// RULE6 - Bit 6 positive, bit 7 negative single-ended enable; the code passes bit 7 only while bit 6 is set
// RULE7 - Driver type: LVDS, CMOS or HCSL
// RULE8 - Channel enable: off, clock, static low, high
// RULE9 - Bit 8 selects normal or slow slew
// RULE10 - Bit 0 selects 1.8 V or higher supply
// RULE11 - Software writes zero to reserved bits
// RULE12 - Ratio is prescale times integer plus fraction
module focc_regs #(
  parameter INT_W  = 8,
  parameter FRAC_W = 20
) (
  input  wire                      clock,
  input  wire                      srst,
  input  wire [7:0]                reg_addr,
  input  wire                      reg_wr,
  input  wire [15:0]               reg_wdata,
  input  wire                      reg_rd,
  output reg  [15:0]               reg_rdata,
  output reg  [INT_W:0]            chan6_integer_divider,
  output reg  [FRAC_W-1:0]         chan6_fraction_value,
  output reg  [INT_W+FRAC_W+2:0]   chan6_total_ratio,
  output reg  [2:0]                chan6_prescale_factor,
  output reg                       chan6_prescale_reserved,
  output reg                       chan6_fraction_enable,
  output reg                       chan6_edge_rate,
  output reg                       chan6_pos_single_enable,
  output reg                       chan6_neg_single_enable,
  output reg  [2:0]                chan6_driver_type,
  output reg  [3:0]                chan6_output_enable,
  output reg                       chan6_supply_range,
  output reg  [2:0]                chan7_prescale_factor,
  output reg                       chan7_prescale_reserved,
  output reg                       chan7_fraction_enable,
  output reg                       chan7_edge_rate,
  output reg                       chan7_pos_single_enable,
  output reg                       chan7_neg_single_enable,
  output reg  [2:0]                chan7_driver_type,
  output reg  [3:0]                chan7_output_enable,
  output reg                       chan7_supply_range
);

  reg  [15:0]             ch6_output_config;
  reg  [15:0]             ch6_int_div_frac_high;
  reg  [15:0]             ch6_frac_low;
  reg  [15:0]             ch7_output_config;
  reg  [15:0]             next_rdata;
  wire [FRAC_W-1:0]       next_fraction;
  wire [INT_W:0]          next_int_div;
  wire [INT_W+FRAC_W:0]   next_ratio;
  wire [2:0]              next_pre6;
  wire [2:0]              next_pre7;
  wire [INT_W+FRAC_W+3:0] next_product;

  // Pre-divider factor, bypass gives one, reserved gives zero
  function [2:0] focc_prescale;
    input [15:0] cfg;
    begin
      if (!cfg[`FOCC_FRAC_EN_BIT])
        focc_prescale = `FOCC_PRE_BYPASS; // RULE4
      else
        case (cfg[`FOCC_PRESCALE_HI:`FOCC_PRESCALE_LO]) // RULE3
          `FOCC_PRE_CODE_DIV2: focc_prescale = `FOCC_PRE_DIV2;
          `FOCC_PRE_CODE_DIV3: focc_prescale = `FOCC_PRE_DIV3;
          `FOCC_PRE_CODE_DIV1: focc_prescale = `FOCC_PRE_DIV1;
          default:             focc_prescale = `FOCC_PRE_RESERVED;
        endcase
    end
  endfunction

  // One-hot driver type: bit0 LVDS, bit1 CMOS, bit2 HCSL
  function [2:0] focc_driver;
    input [15:0] cfg;
    begin
      case (cfg[`FOCC_DRV_HI:`FOCC_DRV_LO]) // RULE7
        `FOCC_DRV_CMOS: focc_driver = 3'h2;
        `FOCC_DRV_HCSL: focc_driver = 3'h4;
        default:        focc_driver = 3'h1;
      endcase
    end
  endfunction

  // One-hot output mode: bit0 off, bit1 clock, bit2 static low, bit3 static high
  function [3:0] focc_mode;
    input [15:0] cfg;
    begin
      case (cfg[`FOCC_OUT_EN_HI:`FOCC_OUT_EN_LO]) // RULE8
        `FOCC_EN_CLOCK: focc_mode = 4'h2;
        `FOCC_EN_LOW:   focc_mode = 4'h4;
        `FOCC_EN_HIGH:  focc_mode = 4'h8;
        default:        focc_mode = 4'h1;
      endcase
    end
  endfunction

  assign next_fraction = {ch6_int_div_frac_high[`FOCC_FRACHI_HI:`FOCC_FRACHI_LO],
                          ch6_frac_low}; // RULE2
  assign next_int_div  = {1'b0, ch6_int_div_frac_high[`FOCC_INTDIV_HI:`FOCC_INTDIV_LO]}
                         + {{INT_W{1'b0}}, 1'b1}; // RULE1
  assign next_ratio    = {next_int_div, next_fraction}; // RULE12
  assign next_pre6     = focc_prescale(ch6_output_config);
  assign next_pre7     = focc_prescale(ch7_output_config);
  // Full-width product, cut to the output width below
  assign next_product  = {3'h0, next_ratio}
                         * {{INT_W+FRAC_W+1{1'b0}}, next_pre6}; // RULE12

  // Register writes; reserved bits are stored as written
  always @(posedge clock)
  begin
    if (srst)
    begin
      ch6_output_config     <= `FOCC_REG_RESET;
      ch6_int_div_frac_high <= `FOCC_REG_RESET;
      ch6_frac_low          <= `FOCC_REG_RESET;
      ch7_output_config     <= `FOCC_REG_RESET;
    end
    else if (reg_wr)
    begin
      case (reg_addr) // RULE11
        `FOCC_CH6_CFG_ADDR:    ch6_output_config     <= reg_wdata;
        `FOCC_CH6_INTDIV_ADDR: ch6_int_div_frac_high <= reg_wdata;
        `FOCC_CH6_FRACLO_ADDR: ch6_frac_low          <= reg_wdata;
        `FOCC_CH7_CFG_ADDR:    ch7_output_config     <= reg_wdata;
        default:               ch6_frac_low          <= ch6_frac_low;
      endcase
    end
  end

  // Read mux
  always @*
  begin
    case (reg_addr)
      `FOCC_CH6_CFG_ADDR:    next_rdata = ch6_output_config;
      `FOCC_CH6_INTDIV_ADDR: next_rdata = ch6_int_div_frac_high;
      `FOCC_CH6_FRACLO_ADDR: next_rdata = ch6_frac_low;
      `FOCC_CH7_CFG_ADDR:    next_rdata = ch7_output_config;
      default:               next_rdata = `FOCC_READ_UNMAPPED;
    endcase
  end

  // Read data holds until the next read or reset
  always @(posedge clock)
  begin
    if (srst)
      reg_rdata <= `FOCC_READ_UNMAPPED;
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end

  // Channel 6 decoded controls
  always @(posedge clock)
  begin
    if (srst)
    begin
      chan6_integer_divider   <= {INT_W+1{1'b0}};
      chan6_fraction_value    <= {FRAC_W{1'b0}};
      chan6_total_ratio       <= {INT_W+FRAC_W+3{1'b0}};
      chan6_prescale_factor   <= `FOCC_PRE_RESERVED;
      chan6_prescale_reserved <= 1'b0;
      chan6_fraction_enable   <= 1'b0;
      chan6_edge_rate         <= 1'b0;
      chan6_pos_single_enable <= 1'b0;
      chan6_neg_single_enable <= 1'b0;
      chan6_driver_type       <= 3'h0;
      chan6_output_enable     <= 4'h0;
      chan6_supply_range      <= 1'b0;
    end
    else
    begin
      chan6_integer_divider   <= next_int_div; // RULE1
      chan6_fraction_value    <= next_fraction; // RULE2
      chan6_total_ratio       <= next_product[INT_W+FRAC_W+2:0]; // RULE12
      chan6_prescale_factor   <= next_pre6; // RULE3
      chan6_prescale_reserved <= (next_pre6 == `FOCC_PRE_RESERVED);
      chan6_fraction_enable   <= ch6_output_config[`FOCC_FRAC_EN_BIT]; // RULE5
      chan6_edge_rate         <= ch6_output_config[`FOCC_EDGE_BIT]; // RULE9
      chan6_pos_single_enable <= ch6_output_config[`FOCC_POS_EN_BIT]; // RULE6
      chan6_neg_single_enable <= ch6_output_config[`FOCC_NEG_EN_BIT]
                                 & ch6_output_config[`FOCC_POS_EN_BIT]; // RULE6
      chan6_driver_type       <= focc_driver(ch6_output_config); // RULE7
      chan6_output_enable     <= focc_mode(ch6_output_config); // RULE8
      chan6_supply_range      <= ch6_output_config[`FOCC_SUPPLY_BIT]; // RULE10
    end
  end

  // Channel 7 decoded controls
  always @(posedge clock)
  begin
    if (srst)
    begin
      chan7_prescale_factor   <= `FOCC_PRE_RESERVED;
      chan7_prescale_reserved <= 1'b0;
      chan7_fraction_enable   <= 1'b0;
      chan7_edge_rate         <= 1'b0;
      chan7_pos_single_enable <= 1'b0;
      chan7_neg_single_enable <= 1'b0;
      chan7_driver_type       <= 3'h0;
      chan7_output_enable     <= 4'h0;
      chan7_supply_range      <= 1'b0;
    end
    else
    begin
      chan7_prescale_factor   <= next_pre7; // RULE3 RULE4
      chan7_prescale_reserved <= (next_pre7 == `FOCC_PRE_RESERVED);
      chan7_fraction_enable   <= ch7_output_config[`FOCC_FRAC_EN_BIT]; // RULE5
      chan7_edge_rate         <= ch7_output_config[`FOCC_EDGE_BIT]; // RULE9
      chan7_pos_single_enable <= ch7_output_config[`FOCC_POS_EN_BIT]; // RULE6
      chan7_neg_single_enable <= ch7_output_config[`FOCC_NEG_EN_BIT]
                                 & ch7_output_config[`FOCC_POS_EN_BIT]; // RULE6
      chan7_driver_type       <= focc_driver(ch7_output_config); // RULE7
      chan7_output_enable     <= focc_mode(ch7_output_config); // RULE8
      chan7_supply_range      <= ch7_output_config[`FOCC_SUPPLY_BIT]; // RULE10
    end
  end

endmodule // focc_regs

/* test/focc_regs_asserts.sv */
module focc_regs_asserts #(
  parameter INT_W  = 8,
  parameter FRAC_W = 20
) (
  input wire logic              clock,
  input wire logic              srst,
  input wire logic [7:0]        reg_addr,
  input wire logic              reg_wr,
  input wire logic [15:0]       reg_wdata,
  input wire logic [INT_W:0]    chan6_integer_divider,
  input wire logic [FRAC_W-1:0] chan6_fraction_value,
  input wire logic [2:0]        chan6_prescale_factor,
  input wire logic              chan6_fraction_enable,
  input wire logic              chan6_edge_rate,
  input wire logic              chan6_pos_single_enable,
  input wire logic              chan6_neg_single_enable,
  input wire logic [2:0]        chan6_driver_type,
  input wire logic [3:0]        chan6_output_enable,
  input wire logic              chan6_supply_range
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] d1;
  logic [15:0] d2;
  wire         w0f = reg_wr && reg_addr == 8'h0f;
  wire         w10 = reg_wr && reg_addr == 8'h10;
  wire         w11 = reg_wr && reg_addr == 8'h11;
  wire [2:0]   pf  = !d2[9] ? 3'h1 : d2[12:10] == 3'h0 ? 3'h2 :
                     d2[12:10] == 3'h1 ? 3'h3 : d2[12:10] == 3'h7 ? 3'h1 : 3'h0;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Write data two edges back, when decoded outputs show it
  always_ff @(posedge clock)
  begin
    d1 <= reg_wdata;
    d2 <= d1;
  end
  chk_int_div: assert property (w10 |-> ##2 chan6_integer_divider == d2[11:4] + 9'h001)
    else $error("integer divider mismatch");
  chk_frac_high: assert property (w10 |-> ##2 chan6_fraction_value[19:16] == d2[3:0])
    else $error("fraction high mismatch");
  chk_frac_low: assert property (w11 |-> ##2 chan6_fraction_value[15:0] == d2)
    else $error("fraction low mismatch");
  chk_prescale_code: assert property (w0f |-> ##2 chan6_prescale_factor == pf)
    else $error("prescale factor mismatch");
  chk_frac_enable: assert property (w0f |-> ##2 chan6_fraction_enable == d2[9])
    else $error("fraction enable mismatch");
  chk_single_gate: assert property (w0f |-> ##2 {chan6_pos_single_enable, chan6_neg_single_enable} == {d2[6], d2[7] & d2[6]})
    else $error("single-ended enable mismatch");
  chk_driver_type: assert property (w0f |-> ##2 chan6_driver_type == (d2[4] ? (d2[3] ? 3'h4 : 3'h2) : 3'h1))
    else $error("driver type mismatch");
  chk_output_enable: assert property (w0f |-> ##2 chan6_output_enable == 4'h1 << d2[2:1])
    else $error("output enable mismatch");
  chk_slew_supply: assert property (w0f |-> ##2 {chan6_edge_rate, chan6_supply_range} == {d2[8], d2[0]})
    else $error("slew or supply mismatch");
endmodule // focc_regs_asserts

/* test/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, srst, reg_wr, reg_rd;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [8:0]  chan6_integer_divider;
  logic [19:0] chan6_fraction_value;
  logic [30:0] chan6_total_ratio;
  logic [2:0]  chan6_prescale_factor, chan7_prescale_factor, chan6_driver_type, chan7_driver_type;
  logic [3:0]  chan6_output_enable, chan7_output_enable;
  logic        chan6_prescale_reserved, chan6_fraction_enable, chan6_edge_rate, chan6_supply_range;
  logic        chan6_pos_single_enable, chan6_neg_single_enable, chan7_prescale_reserved;
  logic        chan7_fraction_enable, chan7_edge_rate, chan7_pos_single_enable;
  logic        chan7_neg_single_enable, chan7_supply_range;
  int          miscompares, n_compared;
  focc_regs i_focc_regs (
    .clock                   (clock),
    .srst                    (srst),
    .reg_addr                (reg_addr),
    .reg_wr                  (reg_wr),
    .reg_wdata               (reg_wdata),
    .reg_rd                  (reg_rd),
    .reg_rdata               (reg_rdata),
    .chan6_integer_divider   (chan6_integer_divider),
    .chan6_fraction_value    (chan6_fraction_value),
    .chan6_total_ratio       (chan6_total_ratio),
    .chan6_prescale_factor   (chan6_prescale_factor),
    .chan6_prescale_reserved (chan6_prescale_reserved),
    .chan6_fraction_enable   (chan6_fraction_enable),
    .chan6_edge_rate         (chan6_edge_rate),
    .chan6_pos_single_enable (chan6_pos_single_enable),
    .chan6_neg_single_enable (chan6_neg_single_enable),
    .chan6_driver_type       (chan6_driver_type),
    .chan6_output_enable     (chan6_output_enable),
    .chan6_supply_range      (chan6_supply_range),
    .chan7_prescale_factor   (chan7_prescale_factor),
    .chan7_prescale_reserved (chan7_prescale_reserved),
    .chan7_fraction_enable   (chan7_fraction_enable),
    .chan7_edge_rate         (chan7_edge_rate),
    .chan7_pos_single_enable (chan7_pos_single_enable),
    .chan7_neg_single_enable (chan7_neg_single_enable),
    .chan7_driver_type       (chan7_driver_type),
    .chan7_output_enable     (chan7_output_enable),
    .chan7_supply_range      (chan7_supply_range)
  );
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    cmp("read data", e, reg_rdata);
  endtask
  task automatic t_reset;
    cmp("reset state", 32'h0000_0491,
        {chan6_integer_divider[3:0], chan6_prescale_factor, chan6_driver_type,
         chan6_output_enable});
    cmp("reset ratio", 32'h0010_0000, chan6_total_ratio);
    for (int k = 15; k < 19; k++)
      rd(k[7:0], 16'h0000);
    $display("reset test done");
  endtask
  task automatic t_divider;
    wr(8'h10, 16'h0ff5);
    wr(8'h11, 16'habcd);
    @(negedge clock);
    cmp("integer divider", 32'h0000_0100, chan6_integer_divider);
    cmp("fraction", 32'h0005_abcd, chan6_fraction_value);
    cmp("ratio", 32'h1005_abcd, chan6_total_ratio);
    rd(8'h10, 16'h0ff5);
    $display("divider test done");
  endtask
  task automatic t_prescale;
    logic [2:0] f;
    for (int c = 0; c < 9; c++)
    begin
      f = c == 8 ? 3'h1 : c == 0 ? 3'h2 : c == 1 ? 3'h3 : c == 7 ? 3'h1 : 3'h0;
      wr(8'h0f, c == 8 ? 16'h0000 : {3'h0, c[2:0], 10'h200});
      wr(8'h12, c == 8 ? 16'h0000 : {3'h0, c[2:0], 10'h200});
      @(negedge clock);
      cmp("prescale", {f, f, f == 3'h0, f == 3'h0, c != 8, c != 8},
          {chan6_prescale_factor, chan7_prescale_factor, chan6_prescale_reserved,
           chan7_prescale_reserved, chan6_fraction_enable,
           chan7_fraction_enable});
      cmp("scaled ratio", f * 32'h1005_abcd, chan6_total_ratio);
    end
    $display("prescale test done");
  endtask
  task automatic t_fields;
    logic [15:0] v;
    logic [10:0] e;
    for (int i = 0; i < 4; i++)
    begin
      v = {7'h00, i[0], i[0] & i[1], i[1], 1'b0, i[1:0], i[1:0], i[1]};
      e = {i < 2 ? 3'h1 : i == 2 ? 3'h2 : 3'h4, 4'h1 << i, i[0], i[1], i[1], i == 3};
      wr(8'h0f, v);
      wr(8'h12, v);
      @(negedge clock);
      cmp("ch6 fields", e, {chan6_driver_type, chan6_output_enable, chan6_edge_rate, chan6_supply_range, chan6_pos_single_enable, chan6_neg_single_enable});
      cmp("ch7 fields", e, {chan7_driver_type, chan7_output_enable, chan7_edge_rate, chan7_supply_range, chan7_pos_single_enable, chan7_neg_single_enable});
    end
    $display("fields test done");
  endtask
  task automatic t_unmapped;
    wr(8'h13, 16'hffff);
    rd(8'h13, 16'h0000);
    rd(8'h12, 16'h01df);
    wr(8'h0f, 16'h1e5f);
    rd(8'h0f, 16'h1e5f);
    $display("unmapped test done");
  endtask
  task automatic t_midreset;
    @(negedge clock);
    srst = 1'b1;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    @(negedge clock);
    cmp("mid-run reset state", 32'h0000_0491,
        {chan6_integer_divider[3:0], chan6_prescale_factor, chan6_driver_type,
         chan6_output_enable});
    rd(8'h0f, 16'h0000);
    rd(8'h12, 16'h0000);
    $display("mid-run reset test done");
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #100000;
    miscompares++;
    end_of_test();
  end
  initial
  begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    repeat (10) @(negedge clock);
    srst = 1'b0;
    repeat (2) @(negedge clock);
    t_reset();
    t_divider();
    t_prescale();
    t_fields();
    t_unmapped();
    t_midreset();
    end_of_test();
  end
endmodule // testbench
bind focc_regs focc_regs_asserts #(
  .INT_W  (INT_W),
  .FRAC_W (FRAC_W)
) i_focc_regs_asserts (
  .clock                   (clock),
  .srst                    (srst),
  .reg_addr                (reg_addr),
  .reg_wr                  (reg_wr),
  .reg_wdata               (reg_wdata),
  .chan6_integer_divider   (chan6_integer_divider),
  .chan6_fraction_value    (chan6_fraction_value),
  .chan6_prescale_factor   (chan6_prescale_factor),
  .chan6_fraction_enable   (chan6_fraction_enable),
  .chan6_edge_rate         (chan6_edge_rate),
  .chan6_pos_single_enable (chan6_pos_single_enable),
  .chan6_neg_single_enable (chan6_neg_single_enable),
  .chan6_driver_type       (chan6_driver_type),
  .chan6_output_enable     (chan6_output_enable),
  .chan6_supply_range      (chan6_supply_range)
);
